/* File: rtl/raster_pkg.sv */
// Contract
// - Port captures on bus enable falling edge
// - Writes accepted only with chip select low
// - Select low indexes, high writes data register
// - Write input low requests write, else none
// - Data lines are inputs only, never driven
// - Display timing from character clock only
// - Line and frame pulses active high
// - Active area high only inside visible area
// - Fourteen bit refresh address output
// - Five bit character line index output
// - Addresses keep running during vertical retrace
// - Cursor high when cursor equals refresh address
// - Format select picks one of two sets
// - Low selects set zero, high set one
// - Character clock falling edge is active
// - Reset clears counters, address shows start
// - Cursor output active high
package raster_pkg;
  localparam int ADDR_W = 14;
  localparam int ROW_W  = 5;
  localparam logic [4:0] IDX_START_H  = 5'h0c;
  localparam logic [4:0] IDX_START_L  = 5'h0d;
  localparam logic [4:0] IDX_CURSOR_H = 5'h0e;
  localparam logic [4:0] IDX_CURSOR_L = 5'h0f;
  localparam logic [13:0] START_RST  = 14'h0000;
  localparam logic [13:0] CURSOR_RST = 14'h0000;
  // Format set zero
  localparam logic [7:0] F0_H_TOTAL = 8'h63;
  localparam logic [7:0] F0_H_DISP  = 8'h50;
  localparam logic [7:0] F0_H_SYNC  = 8'h54;
  localparam logic [3:0] F0_H_WID   = 4'ha;
  localparam logic [6:0] F0_V_TOTAL = 7'h1e;
  localparam logic [4:0] F0_V_ADJ   = 5'h02;
  localparam logic [6:0] F0_V_DISP  = 7'h18;
  localparam logic [6:0] F0_V_SYNC  = 7'h1b;
  localparam logic [3:0] F0_V_WID   = 4'h3;
  localparam logic [4:0] F0_MAX_ROW = 5'h09;
  // Format set one
  localparam logic [7:0] F1_H_TOTAL = 8'h63;
  localparam logic [7:0] F1_H_DISP  = 8'h50;
  localparam logic [7:0] F1_H_SYNC  = 8'h54;
  localparam logic [3:0] F1_H_WID   = 4'ha;
  localparam logic [6:0] F1_V_TOTAL = 7'h1f;
  localparam logic [4:0] F1_V_ADJ   = 5'h06;
  localparam logic [6:0] F1_V_DISP  = 7'h18;
  localparam logic [6:0] F1_V_SYNC  = 7'h1c;
  localparam logic [3:0] F1_V_WID   = 4'h3;
  localparam logic [4:0] F1_MAX_ROW = 5'h0b;
endpackage : raster_pkg

/* File: rtl/edge_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module edge_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level_out,
  output logic      [W-1:0] fall_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign level_out = s2_q;
  assign fall_out  = s3_q & ~s2_q;
endmodule : edge_sync
`default_nettype wire

/* File: rtl/rom_format_raster_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module rom_format_raster_timer (
  // Clock and reset
  input  wire logic                         CLK,
  input  wire logic                         RESETN,
  // Device reset pin and format strap
  input  wire logic                         DEV_RESET_N,
  input  wire logic                         FORMAT_SELECT,
  // Processor write port
  input  wire logic                         BUS_E,
  input  wire logic                         CS_N,
  input  wire logic                         REG_INDEX_SEL,
  input  wire logic                         WRITE_N,
  input  wire logic [7:0]                   DATA_IN,
  // Character clock
  input  wire logic                         CHAR_CLK,
  // Display outputs
  output logic                              LINE_PULSE,
  output logic                              FRAME_PULSE,
  output logic                              ACTIVE_AREA,
  output logic      [raster_pkg::ADDR_W-1:0] REFRESH_ADDR_OUT,
  output logic      [raster_pkg::ROW_W-1:0]  CHAR_LINE_INDEX,
  output logic                              CURSOR
);
  import raster_pkg::*;

  typedef struct packed {
    logic [4:0]        idx;
    logic [13:0]       start;
    logic [13:0]       cursor;
    logic [7:0]        hcnt;
    logic [4:0]        row;
    logic [6:0]        vrow;
    logic [4:0]        adj;
    logic              in_adj;
    logic [3:0]        lp_cnt;
    logic [3:0]        fp_cnt;
    logic [13:0]       ma;
    logic [13:0]       ma_row;
    logic              line_pulse;
    logic              frame_pulse;
    logic              active;
    logic [13:0]       addr_out;
    logic [4:0]        row_out;
    logic              cur;
  } state_s;

  state_s st_q;
  state_s st_d;

  // Pins from outside the clock domain: E, control, data, char clock, reset, strap
  localparam int SW = 15;
  logic [SW-1:0] s_lvl;
  logic [SW-1:0] s_fall;

  edge_sync #(.W(SW)) edge_sync_inst (
    .clk       (CLK),
    .rst_n     (RESETN),
    .async_in  ({BUS_E, CS_N, REG_INDEX_SEL, WRITE_N, DATA_IN, CHAR_CLK, DEV_RESET_N,
                 FORMAT_SELECT}),
    .level_out (s_lvl),
    .fall_out  (s_fall)
  );

  logic       e_fall;
  logic       cs_n_s;
  logic       rsel_s;
  logic       wr_n_s;
  logic [7:0] data_s;
  logic       cc_fall;
  logic       dres_n_s;
  logic       fmt_s;
  assign e_fall   = s_fall[14];
  assign cs_n_s   = s_lvl[13];
  assign rsel_s   = s_lvl[12];
  assign wr_n_s   = s_lvl[11];
  assign data_s   = s_lvl[10:3];
  assign cc_fall  = s_fall[2];
  assign dres_n_s = s_lvl[1];
  assign fmt_s    = s_lvl[0];

  // Format parameter selection
  logic [7:0] h_total;
  logic [7:0] h_disp;
  logic [7:0] h_sync;
  logic [3:0] h_wid;
  logic [6:0] v_total;
  logic [4:0] v_adj;
  logic [6:0] v_disp;
  logic [6:0] v_sync;
  logic [3:0] v_wid;
  logic [4:0] max_row;

  always_comb begin
    if (fmt_s) begin
      h_total = F1_H_TOTAL;
      h_disp  = F1_H_DISP;
      h_sync  = F1_H_SYNC;
      h_wid   = F1_H_WID;
      v_total = F1_V_TOTAL;
      v_adj   = F1_V_ADJ;
      v_disp  = F1_V_DISP;
      v_sync  = F1_V_SYNC;
      v_wid   = F1_V_WID;
      max_row = F1_MAX_ROW;
    end else begin
      h_total = F0_H_TOTAL;
      h_disp  = F0_H_DISP;
      h_sync  = F0_H_SYNC;
      h_wid   = F0_H_WID;
      v_total = F0_V_TOTAL;
      v_adj   = F0_V_ADJ;
      v_disp  = F0_V_DISP;
      v_sync  = F0_V_SYNC;
      v_wid   = F0_V_WID;
      max_row = F0_MAX_ROW;
    end
  end

  always_comb begin
    logic        line_end;
    logic        row_end;
    logic        frame_end;
    logic        h_act;
    logic        v_act;
    logic [13:0] ma_next;
    st_d      = st_q;
    line_end  = 1'b0;
    row_end   = 1'b0;
    frame_end = 1'b0;
    h_act     = 1'b0;
    v_act     = 1'b0;
    ma_next   = st_q.ma;

    // Processor port, sampled on E falling edge only
    if (e_fall && !cs_n_s && !wr_n_s) begin
      if (!rsel_s) begin
        st_d.idx = data_s[4:0];
      end else begin
        unique case (st_q.idx)
          IDX_START_H:  st_d.start[13:8]  = data_s[5:0];
          IDX_START_L:  st_d.start[7:0]   = data_s;
          IDX_CURSOR_H: st_d.cursor[13:8] = data_s[5:0];
          IDX_CURSOR_L: st_d.cursor[7:0]  = data_s;
          default: ;
        endcase
      end
    end

    if (!dres_n_s) begin
      st_d.hcnt        = '0;
      st_d.row         = '0;
      st_d.vrow        = '0;
      st_d.adj         = '0;
      st_d.in_adj      = 1'b0;
      st_d.lp_cnt      = '0;
      st_d.fp_cnt      = '0;
      st_d.ma          = st_q.start;
      st_d.ma_row      = st_q.start;
      st_d.line_pulse  = 1'b0;
      st_d.frame_pulse = 1'b0;
      st_d.active      = 1'b0;
      st_d.addr_out    = st_q.start;
      st_d.row_out     = '0;
      st_d.cur         = 1'b0;
    end else if (cc_fall) begin
      line_end = (st_q.hcnt == h_total);
      row_end  = line_end && !st_q.in_adj && (st_q.row == max_row);
      // Adjust phase adds exactly v_adj lines before the frame closes
      frame_end = st_q.in_adj ? (line_end && st_q.adj == v_adj - 5'h01)
                              : (row_end && st_q.vrow == v_total && v_adj == 5'h00);
      h_act = (st_q.hcnt < h_disp);
      v_act = (st_q.vrow < v_disp) && !st_q.in_adj;
      // Linear address runs every character, including retrace
      ma_next = st_q.ma + 14'h0001;
      st_d.hcnt = line_end ? 8'h00 : st_q.hcnt + 8'h01;
      if (line_end) begin
        if (frame_end) begin
          st_d.vrow   = '0;
          st_d.row    = '0;
          st_d.adj    = '0;
          st_d.in_adj = 1'b0;
          ma_next     = st_q.start;
          st_d.ma_row = st_q.start;
        end else if (st_q.in_adj) begin
          st_d.adj = st_q.adj + 5'h01;
          st_d.row = st_q.row + 5'h01;
          ma_next  = st_q.ma_row;
        end else if (row_end) begin
          st_d.row    = '0;
          st_d.ma_row = st_q.ma_row + 14'(h_disp);
          ma_next     = st_q.ma_row + 14'(h_disp);
          if (st_q.vrow == v_total) begin
            st_d.in_adj = 1'b1;
          end else begin
            st_d.vrow = st_q.vrow + 7'h01;
          end
        end else begin
          st_d.row = st_q.row + 5'h01;
          ma_next  = st_q.ma_row;
        end
      end
      st_d.ma = ma_next;
      // Horizontal sync
      if (st_q.hcnt == h_sync) begin
        st_d.lp_cnt = h_wid;
      end else if (st_q.lp_cnt != 4'h0) begin
        st_d.lp_cnt = st_q.lp_cnt - 4'h1;
      end
      // Vertical sync, counted in lines
      if (line_end && row_end && st_q.vrow == v_sync) begin
        st_d.fp_cnt = v_wid;
      end else if (line_end && st_q.fp_cnt != 4'h0) begin
        st_d.fp_cnt = st_q.fp_cnt - 4'h1;
      end
      st_d.line_pulse  = (st_d.lp_cnt != 4'h0);
      st_d.frame_pulse = (st_d.fp_cnt != 4'h0);
      st_d.active      = h_act && v_act;
      st_d.addr_out    = st_q.ma;
      st_d.row_out     = st_q.row;
      st_d.cur         = (st_q.cursor == st_q.ma);
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      st_q <= '{idx: 5'h00, start: START_RST, cursor: CURSOR_RST, hcnt: 8'h00, row: 5'h00,
                vrow: 7'h00, adj: 5'h00, in_adj: 1'b0, lp_cnt: 4'h0, fp_cnt: 4'h0,
                ma: START_RST, ma_row: START_RST, line_pulse: 1'b0, frame_pulse: 1'b0,
                active: 1'b0, addr_out: START_RST, row_out: 5'h00, cur: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign LINE_PULSE       = st_q.line_pulse;
  assign FRAME_PULSE      = st_q.frame_pulse;
  assign ACTIVE_AREA      = st_q.active;
  assign REFRESH_ADDR_OUT = st_q.addr_out;
  assign CHAR_LINE_INDEX  = st_q.row_out;
  assign CURSOR           = st_q.cur;
endmodule : rom_format_raster_timer
`default_nettype wire

/* File: verif/raster_checker_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module raster_checker (
  // Clock and resets
  input wire logic                          CLK,
  input wire logic                          RESETN,
  input wire logic                          DEV_RESET_N,
  // Display outputs
  input wire logic                          LINE_PULSE,
  input wire logic                          FRAME_PULSE,
  input wire logic                          ACTIVE_AREA,
  input wire logic [raster_pkg::ADDR_W-1:0] REFRESH_ADDR_OUT,
  input wire logic [raster_pkg::ROW_W-1:0]  CHAR_LINE_INDEX,
  input wire logic                          CURSOR
);
  import raster_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  sequence s_dev_held;
    !DEV_RESET_N [*5];
  endsequence
  sequence s_line_held;
    (LINE_PULSE || !DEV_RESET_N) [*8];
  endsequence
  property p_rst_zero;
    $rose(RESETN) |-> REFRESH_ADDR_OUT == 14'h0000 && !CURSOR && !ACTIVE_AREA;
  endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("outputs not clear after reset");
  property p_dev_low;
    s_dev_held |-> {LINE_PULSE, FRAME_PULSE, ACTIVE_AREA, CURSOR, CHAR_LINE_INDEX} == 9'h000;
  endproperty
  a_dev_low: assert property (p_dev_low) else $error("outputs not low in device reset");
  property p_row_range;
    CHAR_LINE_INDEX <= F1_MAX_ROW;
  endproperty
  a_row_range: assert property (p_row_range) else $error("line index out of range");
  property p_blank;
    LINE_PULSE || FRAME_PULSE |-> !ACTIVE_AREA;
  endproperty
  a_blank: assert property (p_blank) else $error("active area during sync");
  property p_addr_step;
    ACTIVE_AREA && $past(ACTIVE_AREA) && $changed(REFRESH_ADDR_OUT)
      |-> REFRESH_ADDR_OUT == $past(REFRESH_ADDR_OUT) + 14'h0001;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("address did not step by one");
  property p_cursor_fall;
    CURSOR && DEV_RESET_N ##1 !CURSOR |-> $changed(REFRESH_ADDR_OUT);
  endproperty
  a_cursor_fall: assert property (p_cursor_fall) else $error("cursor dropped on same address");
  property p_row_step;
    $changed(CHAR_LINE_INDEX) && DEV_RESET_N |-> $changed(REFRESH_ADDR_OUT);
  endproperty
  a_row_step: assert property (p_row_step) else $error("line index moved without step");
  property p_line_width;
    $rose(LINE_PULSE) |-> s_line_held;
  endproperty
  a_line_width: assert property (p_line_width) else $error("line pulse too short");
endmodule : raster_checker
bind rom_format_raster_timer raster_checker raster_checker_inst (
  .CLK(CLK), .RESETN(RESETN), .DEV_RESET_N(DEV_RESET_N), .LINE_PULSE(LINE_PULSE),
  .FRAME_PULSE(FRAME_PULSE), .ACTIVE_AREA(ACTIVE_AREA), .REFRESH_ADDR_OUT(REFRESH_ADDR_OUT),
  .CHAR_LINE_INDEX(CHAR_LINE_INDEX), .CURSOR(CURSOR));
`default_nettype wire

/* File: verif/cpu_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
  // Clock
  input  wire logic       clk,
  // Processor bus
  output logic            bus_e,
  output logic            cs_n,
  output logic            rsel,
  output logic            w_n,
  output logic      [7:0] data
);
  initial begin
    bus_e = 1'b0;
    cs_n  = 1'b1;
    rsel  = 1'b0;
    w_n   = 1'b1;
    data  = 8'h00;
  end
  // One bus cycle, all qualifiers steady around the falling enable
  task automatic cycle(input logic c, input logic r, input logic w, input logic [7:0] d);
    @(negedge clk);
    cs_n  = c;
    rsel  = r;
    w_n   = w;
    data  = d;
    bus_e = 1'b1;
    repeat (4) @(negedge clk);
    bus_e = 1'b0;
    repeat (4) @(negedge clk);
    cs_n  = 1'b1;
    w_n   = 1'b1;
    data  = ~d;
  endtask : cycle
endmodule : cpu_bus_model
`default_nettype wire

/* File: verif/rom_format_raster_timer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module rom_format_raster_timer_bench;
  import raster_pkg::*;
  logic        clk, resetn, dev_n, fmt, cclk, e, cs_n, rsel, w_n, lp, fp, act, cur, mon;
  logic [7:0]  d;
  logic [13:0] addr, cur_exp;
  logic [4:0]  row, row_max;
  int          failures, n_tests, cyc, hits;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    cclk = 1'b0;
    #1.3;
    forever #32 cclk = ~cclk;
  end
  rom_format_raster_timer rom_format_raster_timer_inst (.CLK(clk), .RESETN(resetn),
    .DEV_RESET_N(dev_n), .FORMAT_SELECT(fmt), .BUS_E(e), .CS_N(cs_n), .REG_INDEX_SEL(rsel),
    .WRITE_N(w_n), .DATA_IN(d), .CHAR_CLK(cclk), .LINE_PULSE(lp), .FRAME_PULSE(fp),
    .ACTIVE_AREA(act), .REFRESH_ADDR_OUT(addr), .CHAR_LINE_INDEX(row), .CURSOR(cur));
  cpu_bus_model cpu_bus_model_inst (.clk(clk), .bus_e(e), .cs_n(cs_n), .rsel(rsel), .w_n(w_n),
    .data(d));
  // Outputs are looked at mid-cycle, away from the edge that launches them
  always @(negedge clk) begin
    if (row > row_max) row_max <= row;
    if (mon && cur === 1'b1) hits++;
    if (mon) chk("cursor", {13'h0, addr == cur_exp}, {13'h0, cur});
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic chk(input string n, input logic [13:0] x, input logic [13:0] g);
    n_tests++;
    if (g !== x) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic wr(input logic [4:0] i, input logic [7:0] v);
    cpu_bus_model_inst.cycle(1'b0, 1'b0, 1'b0, {3'h0, i});
    cpu_bus_model_inst.cycle(1'b0, 1'b1, 1'b0, v);
  endtask : wr
  task automatic dev_rst(input logic [13:0] x);
    @(negedge clk);
    dev_n = 1'b0;
    repeat (8) @(negedge clk);
    chk("reset addr", x, addr);
    chk("reset outputs", 14'h0, {5'h0, lp, fp, act, cur, row});
    dev_n = 1'b1;
  endtask : dev_rst
  task automatic lines(input int n);
    repeat (n) begin
      while (lp !== 1'b1) @(negedge clk);
      while (lp !== 1'b0) @(negedge clk);
    end
  endtask : lines
  task automatic t_start();
    chk("addr after reset", 14'h0000, addr);
    wr(IDX_START_H, 8'h12);
    wr(IDX_START_L, 8'h34);
    dev_rst(14'h1234);
    while (act !== 1'b1) @(negedge clk);
    chk("first addr", 14'h1234, addr);
    chk("first row", 14'h0000, {9'h0, row});
    while (row !== 5'h01) @(negedge clk);
    while (!(act === 1'b1 && row === 5'h00)) @(negedge clk);
    chk("next row addr", 14'h1284, addr);
  endtask : t_start
  task automatic t_refuse();
    cpu_bus_model_inst.cycle(1'b1, 1'b1, 1'b0, 8'h3f);
    cpu_bus_model_inst.cycle(1'b0, 1'b1, 1'b1, 8'h3f);
    wr(5'h05, 8'h2a);
    dev_rst(14'h1234);
  endtask : t_refuse
  task automatic t_cursor();
    wr(IDX_CURSOR_H, 8'h12);
    wr(IDX_CURSOR_L, 8'h37);
    cur_exp = 14'h1237;
    dev_rst(14'h1234);
    mon = 1'b1;
    lines(1);
    mon = 1'b0;
    chk("cursor hits", 14'h0001, {13'h0, hits != 0});
  endtask : t_cursor
  task automatic t_format();
    fmt = 1'b1;
    dev_rst(14'h1234);
    row_max = 5'h00;
    lines(13);
    chk("max row set one", {9'h0, F1_MAX_ROW}, {9'h0, row_max});
    fmt = 1'b0;
    dev_rst(14'h1234);
    row_max = 5'h00;
    lines(12);
    chk("max row set zero", {9'h0, F0_MAX_ROW}, {9'h0, row_max});
  endtask : t_format
  task automatic tally_and_finish();
    if (failures == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    {resetn, fmt, mon, row_max, cur_exp, failures, n_tests, cyc, hits} = '0;
    dev_n = 1'b1;
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    t_start();
    t_refuse();
    t_cursor();
    t_format();
    tally_and_finish();
  end
endmodule : rom_format_raster_timer_bench
`default_nettype wire
